// ### design/opp_pkg.sv
// constants and carrier types for the otp programming port
package opp_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int ARRAY_BYTES = 32768;
    localparam int ARR_IDX_W = 15;
    // run-mode base of the array, subtracted to get programming address
    localparam logic [16:0] RUN_BASE = 17'h08000;
    localparam logic [16:0] PROG_TOP = 17'h07FFF;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] OUT_OF_RANGE = 8'hFF;
    // program strobe width and the sampled-cycle count for it
    localparam int CLK_PERIOD_NS = 100;
    localparam int PULSE_NS = 100000;
    localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
    localparam int PCNT_W = 14;

    // control strobes as sampled from pins, all active low
    typedef struct packed {
        logic chip_sel_n;
        logic read_en_n;
        logic program_strobe_n;
    } opp_ctl_t;

    typedef enum logic [1:0] {
        OPP_IDLE = 2'b00,
        OPP_PULSE = 2'b01,
        OPP_WRITE = 2'b11
    } opp_state_t;
endpackage

// ### design/opp_port.sv
// otp program memory with its parallel programming-mode port
//
// Behaviour
// - 17-bit programming address taken on prog_addr pins
// - 8-bit two-way data bus: write data in, verify data out
// - active-low chip-select and read-enable gate array reads
// - one 0.1 ms low program strobe writes presented byte to address
// - run-mode image relocated by subtracting 0x8000 before programming
// - no electronic signature readout; programmer must not request one
// - 32 KB array at 0x8000-0xFFFF run, 0x0000-0x7FFF programming
`timescale 1ns/1ns
module opp_port
    import opp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic PROG_MODE,
    input wire logic [opp_pkg::ADDR_W-1:0] PROG_ADDR,
    input wire logic [opp_pkg::DATA_W-1:0] PROG_DATA_IN,
    output logic [opp_pkg::DATA_W-1:0] PROG_DATA_OUT,
    output logic PROG_DATA_OE,
    input wire opp_pkg::opp_ctl_t PROG_CTL,
    input wire logic [opp_pkg::ARR_IDX_W-1:0] RUN_ADDR,
    output logic [opp_pkg::DATA_W-1:0] RUN_DATA
);
    import opp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [ADDR_W-1:0] addr_m, addr_s;
    logic [DATA_W-1:0] din_m, din_s;
    opp_ctl_t ctl_m, ctl_s;
    logic mode_m, mode_s;

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            addr_m <= '0;
            addr_s <= '0;
            din_m <= '0;
            din_s <= '0;
            ctl_m <= 3'h7;
            ctl_s <= 3'h7;
            mode_m <= 1'b0;
            mode_s <= 1'b0;
        end
        else
        begin
            addr_m <= PROG_ADDR;
            addr_s <= addr_m;
            din_m <= PROG_DATA_IN;
            din_s <= din_m;
            ctl_m <= PROG_CTL;
            ctl_s <= ctl_m;
            mode_m <= PROG_MODE;
            mode_s <= mode_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array storage; cells start erased
    // no reset on the cells: a chip reset must never look like an erase
    logic [DATA_W-1:0] mem [ARRAY_BYTES] = '{default: ERASED};
    logic in_range;
    logic [ARR_IDX_W-1:0] idx;
    logic wr_now;

    assign in_range = (addr_s <= PROG_TOP);
    assign idx = addr_s[ARR_IDX_W-1:0];

    always_ff @(posedge CLK_SYS)
    begin
        if (wr_now)
        begin
            // otp cells only lose ones: program by and-ing
            mem[idx] <= mem[idx] & din_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program strobe sequencer
    opp_state_t state;
    logic [PCNT_W-1:0] pcnt;
    logic strobe_low;

    assign strobe_low = mode_s && !ctl_s.chip_sel_n &&
        !ctl_s.program_strobe_n;
    assign wr_now = (state == OPP_WRITE) && in_range;

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            state <= OPP_IDLE;
            pcnt <= '0;
        end
        else
        begin
            unique case (state)
                OPP_IDLE:
                begin
                    pcnt <= '0;
                    if (strobe_low)
                    begin
                        state <= OPP_PULSE;
                    end
                end
                OPP_PULSE:
                begin
                    if (pcnt != PCNT_W'(PULSE_CYC))
                    begin
                        pcnt <= pcnt + 1'b1;
                    end
                    // write once the strobe rises after a long enough low
                    if (!strobe_low)
                    begin
                        state <= (pcnt >= PCNT_W'(PULSE_CYC - 1)) ?
                            OPP_WRITE : OPP_IDLE;
                    end
                end
                OPP_WRITE:
                begin
                    state <= OPP_IDLE;
                end
                default:
                begin
                    state <= OPP_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; no signature decode exists on addr9
    logic rd_en;
    assign rd_en = mode_s && !ctl_s.chip_sel_n && !ctl_s.read_en_n &&
        ctl_s.program_strobe_n;

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            PROG_DATA_OUT <= '0;
            PROG_DATA_OE <= 1'b0;
        end
        else
        begin
            PROG_DATA_OE <= rd_en;
            PROG_DATA_OUT <= in_range ? mem[idx] : OUT_OF_RANGE;
        end
    end

    // run-mode view: index is run address minus base, i.e. low 15 bits
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            RUN_DATA <= '0;
        end
        else
        begin
            RUN_DATA <= mem[RUN_ADDR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_oe_gating: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        PROG_DATA_OE |-> $past(rd_en))
        else $error("data bus driven outside read window");
    chk_oe_strobe: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !ctl_s.program_strobe_n |=> !PROG_DATA_OE)
        else $error("data bus driven during program strobe");
    chk_read_sel: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        (ctl_s.chip_sel_n || ctl_s.read_en_n) |=> !PROG_DATA_OE)
        else $error("read without select and read enable");
    chk_oe_mode: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !mode_s |=> !PROG_DATA_OE)
        else $error("data bus driven outside programming mode");
    chk_write_after: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        (state == OPP_WRITE) |-> $past(state) == OPP_PULSE)
        else $error("write not preceded by strobe");
    chk_short_pulse: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        (state == OPP_PULSE && !strobe_low && pcnt < PCNT_W'(PULSE_CYC - 1))
        |=> state == OPP_IDLE)
        else $error("short strobe caused a write");
    chk_idle_mode: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        (!mode_s && state == OPP_IDLE) |=> state == OPP_IDLE)
        else $error("strobe accepted outside programming mode");
    chk_write_one: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        (state == OPP_WRITE) |=> state == OPP_IDLE)
        else $error("write held more than one cycle");
    chk_write_cell: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        wr_now |=> mem[$past(idx)] == ($past(mem[idx]) & $past(din_s)))
        else $error("programmed cell not the and of old and new data");
    chk_range_data: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        !in_range |=> PROG_DATA_OUT == OUT_OF_RANGE)
        else $error("out of range read not 0xFF");
    chk_addr_path: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ##2 addr_s == $past(PROG_ADDR, 2))
        else $error("address path broken");
    chk_run_view: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        1'b1 |=> RUN_DATA == $past(mem[RUN_ADDR]))
        else $error("run view does not follow the array");
endmodule

// ### bench/opp_prgm.sv
// programmer model on the far side of the programming pins
`timescale 1ns/1ns
module opp_prgm(
    input wire logic clk,
    output logic mode,
    output logic drv,
    output logic [16:0] addr,
    output logic [7:0] data,
    output opp_pkg::opp_ctl_t ctl,
    input wire logic [7:0] bus,
    input wire logic oe
);
    import opp_pkg::*;
    initial
    begin
        mode = 1'b0;
        drv = 1'b0;
        addr = 17'h00000;
        data = 8'h00;
        ctl = 3'b111;
    end
    task automatic enter;
        @(posedge clk);
        mode <= 1'b1;
    endtask
    task automatic leave;
        @(posedge clk);
        mode <= 1'b0;
    endtask
    // strobe of w cycles with select low; pins held a while after
    task automatic pulse(input logic [16:0] a, input logic [7:0] d,
        input int w);
        @(posedge clk);
        addr <= a;
        data <= d;
        drv <= 1'b1;
        ctl <= 3'b011;
        @(posedge clk);
        ctl <= 3'b010;
        repeat (w) @(posedge clk);
        ctl <= 3'b011;
        repeat (6) @(posedge clk);
        ctl <= 3'b111;
        drv <= 1'b0;
    endtask
    task automatic rd_byte(input logic [16:0] a, output logic [7:0] d,
        output logic o);
        @(posedge clk);
        addr <= a;
        ctl <= 3'b001;
        repeat (5) @(posedge clk);
        d = bus;
        o = oe;
        ctl <= 3'b111;
        repeat (5) @(posedge clk);
    endtask
    task automatic burn(input logic [16:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic o;
        for (int i = 0; i < 25; i++)
        begin
            pulse(a, d, 1005);
            rd_byte(a, q, o);
            if (q === d)
                break;
        end
    endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the otp programming port
`timescale 1ns/1ns
module testbench;
    import opp_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic mode, drv, oe, o;
    logic [16:0] addr;
    logic [7:0] wd, dout, pin, run_data, q;
    logic [14:0] run_addr = 15'h0000;
    opp_ctl_t ctl;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    // released lines show the inverse of the last value
    assign pin = oe ? dout : (drv ? wd : ~wd);
    opp_port uut(.CLK_SYS(clk), .NRST(nrst), .PROG_MODE(mode),
        .PROG_ADDR(addr), .PROG_DATA_IN(pin), .PROG_DATA_OUT(dout),
        .PROG_DATA_OE(oe), .PROG_CTL(ctl), .RUN_ADDR(run_addr),
        .RUN_DATA(run_data));
    opp_prgm prg(.clk(clk), .mode(mode), .drv(drv), .addr(addr),
        .data(wd), .ctl(ctl), .bus(pin), .oe(oe));
    task automatic finish_test;
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdc(input logic [16:0] a, input logic [7:0] e);
        prg.rd_byte(a, q, o);
        cmp("prog_data", e, q);
        cmp("oe on", 8'h01, {7'h00, o});
        cmp("oe off", 8'h00, {7'h00, oe});
    endtask
    task automatic t_reset;
        cmp("reset oe", 8'h00, {7'h00, oe});
        cmp("reset run", 8'h00, run_data);
    endtask
    task automatic t_burn;
        prg.burn(17'h00005, 8'h5A, q);
        cmp("burn", 8'h5A, q);
        prg.burn(17'h00200, 8'h3C, q);
        rdc(17'h00200, 8'h3C);
        prg.leave();
        prg.rd_byte(17'h00005, q, o);
        cmp("oe run mode", 8'h00, {7'h00, o});
        run_addr <= 15'h0005;
        repeat (3) @(posedge clk);
        cmp("run_data", 8'h5A, run_data);
        prg.enter();
    endtask
    task automatic t_short;
        prg.pulse(17'h00006, 8'h00, 500);
        rdc(17'h00006, ERASED);
    endtask
    task automatic t_range;
        prg.pulse(17'h08006, 8'h00, 1005);
        rdc(17'h08006, OUT_OF_RANGE);
        rdc(17'h00006, ERASED);
    endtask
    task automatic t_and;
        prg.pulse(17'h00005, 8'h0F, 1005);
        rdc(17'h00005, 8'h0A);
    endtask
    task automatic t_verify;
        prg.burn(17'h00007, 8'hFF, q);
        cmp("fill", 8'hFF, q);
        rdc(17'h00000, ERASED);
        rdc(17'h02000, ERASED);
        rdc(17'h04000, ERASED);
        rdc(17'h00005, 8'h0A);
        rdc(17'h00200, 8'h3C);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            finish_test();
        end
    end
    initial
    begin
        repeat (19) @(posedge clk);
        @(negedge clk);
        t_reset();
        @(posedge clk);
        nrst <= 1'b1;
        prg.enter();
        rdc(17'h07FFF, ERASED);
        t_burn();
        t_short();
        t_range();
        t_and();
        t_verify();
        finish_test();
    end
endmodule
